// ===== design/coag_opfmt.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// operand formatter: bit select, bcd split, size masking
module coag_opfmt
   import coag_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // raw operand
   input wire logic [COAG_DW-1:0] raw_i,
   input wire coag_size_e size_i,
   input wire logic [2:0] bit_sel_i,
   // formatted operand
   output logic [COAG_DW-1:0] fmt_o,
   output logic [3:0] bcd_hi_o,
   output logic [3:0] bcd_lo_o,
   output logic bit_o
);
   logic [COAG_DW-1:0] fmt_d, fmt_q;   // size-masked value
   logic [3:0] hi_d, hi_q, lo_d, lo_q; // packed digits
   logic bit_d, bit_q;                 // selected bit

   // next values
   always_comb begin
      fmt_d = raw_i;
      hi_d = raw_i[7:4];   // [RULE3]
      lo_d = raw_i[3:0];   // [RULE3]
      bit_d = raw_i[bit_sel_i]; // bit 0..7 of the byte [RULE2]
      case (size_i)   // [RULE1]
         COAG_S_BIT: fmt_d = {31'h0, raw_i[bit_sel_i]};
         COAG_S_BCD: fmt_d = {24'h0, raw_i[7:0]};
         COAG_S_BYTE: fmt_d = {24'h0, raw_i[7:0]};
         COAG_S_WORD: fmt_d = {16'h0, raw_i[15:0]};
         default: fmt_d = raw_i;
      endcase
   end

   // registers
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fmt_q <= '0;
         hi_q <= 4'h0;
         lo_q <= 4'h0;
         bit_q <= 1'b0;
      end else begin
         fmt_q <= fmt_d;
         hi_q <= hi_d;
         lo_q <= lo_d;
         bit_q <= bit_d;
      end
   end

   assign fmt_o = fmt_q;
   assign bcd_hi_o = hi_q;
   assign bcd_lo_o = lo_q;
   assign bit_o = bit_q;

   // byte operand yields two digits
   bcd_split_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE3]
      (size_i == COAG_S_BCD) |=> ({bcd_hi_o, bcd_lo_o} == $past(raw_i[7:0])))
      else $error("bcd digits do not rebuild byte");
endmodule
`default_nettype wire

// ===== design/coag_pkg.sv
package coag_pkg;
   // ==========================================
   // address and operand widths
   localparam int COAG_AW = 24;           // program counter width
   localparam int COAG_SPACE_W = 16;      // implemented address space
   localparam int COAG_DW = 32;           // widest operand
   localparam logic [7:0] COAG_SHORT_PAGE = 8'hff;   // page of the short absolute form
   localparam logic [7:0] COAG_PTR_PAGE = 8'h00;     // page of indirect pointers
   localparam logic [7:0] COAG_ZERO8 = 8'h00;
   localparam logic [COAG_AW-1:0] COAG_PC_RESET = 24'h000000;
   // ==========================================
   // trap vector table
   localparam logic [7:0] COAG_TRAP_BASE = 8'h10;    // vector 0 byte address
   localparam int COAG_VEC_SHIFT = 2;                // four bytes per vector
   // ==========================================
   // addressing modes presented by decode
   typedef enum logic [3:0] {
      COAG_M_ABS8 = 4'h0,
      COAG_M_ABS16 = 4'h1,
      COAG_M_ABS24 = 4'h2,
      COAG_M_IMM8 = 4'h3,
      COAG_M_IMM16 = 4'h4,
      COAG_M_IMM32 = 4'h5,
      COAG_M_IMPL = 4'h6,
      COAG_M_BITNO = 4'h7,
      COAG_M_TRAP = 4'h8,
      COAG_M_REL8 = 4'h9,
      COAG_M_REL16 = 4'ha,
      COAG_M_IND = 4'hb
   } coag_mode_e;
   // ==========================================
   // operand sizes
   typedef enum logic [2:0] {
      COAG_S_BIT = 3'h0,
      COAG_S_BCD = 3'h1,
      COAG_S_BYTE = 3'h2,
      COAG_S_WORD = 3'h3,
      COAG_S_LONG = 3'h4
   } coag_size_e;
   // ==========================================
   // sequencer states
   typedef enum logic [1:0] {
      COAG_ST_IDLE = 2'b00,
      COAG_ST_FETCH = 2'b01,
      COAG_ST_DONE = 2'b10
   } coag_state_e;
endpackage

// ===== design/coag_top.sv
// Operation
// RULE1 - operands: bit, bcd, byte, word, longword
// RULE2 - bit ops pick bit 0..7
// RULE3 - decimal adjusts see two bcd digits
// RULE4 - absolute drops top byte; short hits ff page
// RULE5 - immediate 8, 16 or 32 bits inline
// RULE6 - small constants implied by opcode
// RULE7 - 3-bit opcode field selects bit
// RULE8 - 2-bit trap field selects vector
// RULE9 - relative: sign-extended displacement plus pc
// RULE10 - base pc is next instruction address
// RULE11 - relative mode serves subroutine branch
// RULE12 - indirect: 8-bit address locates target
// RULE13 - pointer fetched with one longword read
// RULE14 - pointer top byte ignored, 24 bits
// RULE15 - pointer address zero-filled, low page
`timescale 1ns/10ps
`default_nettype none
module coag_top
   import coag_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // decode request
   input wire logic req_i,
   input wire coag_mode_e mode_i,
   input wire coag_size_e size_i,
   input wire logic [COAG_AW-1:0] next_pc_i,  // first byte of next instruction
   input wire logic [COAG_DW-1:0] ext_i,      // extension word(s) of the opcode
   input wire logic [2:0] op_field_i,         // low opcode field
   input wire logic [1:0] small_k_i,          // implied-constant select
   input wire logic is_bsr_i,
   // memory bus
   output logic mem_req_o,
   output logic [COAG_SPACE_W-1:0] mem_addr_o,
   output logic mem_long_o,
   input wire logic mem_ack_i,
   input wire logic [COAG_DW-1:0] mem_rdata_i,
   // results
   output logic done_o,
   output logic [COAG_SPACE_W-1:0] ea_o,
   output logic [COAG_AW-1:0] target_o,
   output logic [COAG_DW-1:0] operand_o,
   output logic [3:0] bcd_hi_o,
   output logic [3:0] bcd_lo_o,
   output logic bit_o,
   output logic busy_o
);
   // ==========================================
   // state
   coag_state_e st_d, st_q;                    // sequencer
   logic [COAG_SPACE_W-1:0] ea_d, ea_q;         // effective address
   logic [COAG_AW-1:0] tgt_d, tgt_q;            // branch target
   logic [COAG_DW-1:0] opnd_d, opnd_q;          // immediate / constant
   logic [2:0] bsel_d, bsel_q;                  // selected bit number
   logic done_d, done_q;                        // completion pulse
   logic [COAG_AW-1:0] disp;                    // sign-extended displacement
   logic [COAG_DW-1:0] kval;                    // implied constant

   // ==========================================
   // implied constant table: 1, 2, 4
   always_comb begin
      case (small_k_i)   // [RULE6]
         2'h1: kval = 32'h00000002;
         2'h2: kval = 32'h00000004;
         default: kval = 32'h00000001;
      endcase
   end

   // ==========================================
   // sequencer next values
   always_comb begin
      st_d = st_q;
      ea_d = ea_q;
      tgt_d = tgt_q;
      opnd_d = opnd_q;
      bsel_d = bsel_q;
      done_d = 1'b0;
      disp = '0;
      case (st_q)
         COAG_ST_IDLE: begin
            if (req_i) begin
               st_d = COAG_ST_DONE;
               case (mode_i)
                  // absolute forms: long form drops top byte, short form lands in ff page
                  COAG_M_ABS8: ea_d = {COAG_SHORT_PAGE, ext_i[7:0]};  // [RULE4]
                  COAG_M_ABS16: ea_d = ext_i[15:0];                   // [RULE4]
                  COAG_M_ABS24: ea_d = ext_i[15:0];                   // [RULE4]
                  // immediates
                  COAG_M_IMM8: opnd_d = {24'h0, ext_i[7:0]};          // [RULE5]
                  COAG_M_IMM16: opnd_d = {16'h0, ext_i[15:0]};        // [RULE5]
                  COAG_M_IMM32: opnd_d = ext_i;                       // [RULE5]
                  COAG_M_IMPL: opnd_d = kval;                         // [RULE6]
                  COAG_M_BITNO: begin
                     bsel_d = op_field_i;                             // [RULE7]
                     // byte operand that holds the selected bit
                     opnd_d = {24'h0, ext_i[7:0]};                    // [RULE2]
                  end
                  COAG_M_TRAP: begin
                     // vector address from 2-bit field
                     ea_d = {COAG_ZERO8, COAG_TRAP_BASE} +
                        ({14'h0, op_field_i[1:0]} << COAG_VEC_SHIFT); // [RULE8]
                  end
                  // relative, base is next pc
                  COAG_M_REL8: begin
                     disp = {{16{ext_i[7]}}, ext_i[7:0]};             // [RULE9]
                     tgt_d = next_pc_i + disp;                        // [RULE10] [RULE11]
                  end
                  COAG_M_REL16: begin
                     disp = {{8{ext_i[15]}}, ext_i[15:0]};            // [RULE9]
                     tgt_d = next_pc_i + disp;                        // [RULE10] [RULE11]
                  end
                  // indirect: pointer in low page
                  COAG_M_IND: begin
                     ea_d = {COAG_PTR_PAGE, ext_i[7:0]};              // [RULE12] [RULE15]
                     st_d = COAG_ST_FETCH;
                  end
                  default: st_d = COAG_ST_DONE;
               endcase
            end
         end
         COAG_ST_FETCH: begin
            // one longword read, top byte dropped
            if (mem_ack_i) begin
               tgt_d = mem_rdata_i[23:0];                             // [RULE13] [RULE14]
               st_d = COAG_ST_DONE;
            end
         end
         default: begin
            done_d = 1'b1;
            st_d = COAG_ST_IDLE;
         end
      endcase
   end

   // ==========================================
   // sequencer registers
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_q <= COAG_ST_IDLE;
         ea_q <= '0;
         tgt_q <= COAG_PC_RESET;
         opnd_q <= '0;
         bsel_q <= 3'h0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ea_q <= ea_d;
         tgt_q <= tgt_d;
         opnd_q <= opnd_d;
         bsel_q <= bsel_d;
         done_q <= done_d;
      end
   end

   // ==========================================
   // operand formatting
   coag_opfmt u_fmt (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .raw_i(opnd_q),
      .size_i(size_i),
      .bit_sel_i(bsel_q),
      .fmt_o(operand_o),
      .bcd_hi_o(bcd_hi_o),
      .bcd_lo_o(bcd_lo_o),
      .bit_o(bit_o)
   );

   // ==========================================
   // outputs
   assign mem_req_o = (st_q == COAG_ST_FETCH);   // [RULE13]
   assign mem_long_o = (st_q == COAG_ST_FETCH);  // [RULE13]
   assign mem_addr_o = ea_q;
   assign ea_o = ea_q;
   assign target_o = tgt_q;
   assign done_o = done_q;
   assign busy_o = (st_q != COAG_ST_IDLE);

   // ==========================================
   // checks
   short_page_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE4]
      (st_q == COAG_ST_IDLE && req_i && mode_i == COAG_M_ABS8) |=>
      (ea_q == {COAG_SHORT_PAGE, $past(ext_i[7:0])}))
      else $error("short absolute not in top page");
   abs_trunc_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE4]
      (st_q == COAG_ST_IDLE && req_i && mode_i == COAG_M_ABS24) |=>
      (ea_q == $past(ext_i[15:0])) ##1 done_o)
      else $error("long absolute not truncated");
   imm_width_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE5]
      (st_q == COAG_ST_IDLE && req_i && mode_i == COAG_M_IMM16) |=>
      (opnd_q == {16'h0, $past(ext_i[15:0])}))
      else $error("immediate word wrong");
   impl_const_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE6]
      (st_q == COAG_ST_IDLE && req_i && mode_i == COAG_M_IMPL) |=>
      (opnd_q == 32'h1 || opnd_q == 32'h2 || opnd_q == 32'h4))
      else $error("implied constant out of set");
   bit_field_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE7]
      (st_q == COAG_ST_IDLE && req_i && mode_i == COAG_M_BITNO) |=>
      (bsel_q == $past(op_field_i)))
      else $error("bit number not from opcode");
   trap_vec_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE8]
      (st_q == COAG_ST_IDLE && req_i && mode_i == COAG_M_TRAP) |=>
      (ea_q[1:0] == 2'b00 && ea_q[15:8] == COAG_ZERO8))
      else $error("trap vector misaligned");
   rel_target_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE9]
      (st_q == COAG_ST_IDLE && req_i && mode_i == COAG_M_REL8) |=>
      (tgt_q == $past(next_pc_i) + {{16{$past(ext_i[7])}}, $past(ext_i[7:0])}))
      else $error("relative target wrong");
   // subroutine branch uses the word displacement off the next pc
   rel_bsr_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE10] [RULE11]
      (st_q == COAG_ST_IDLE && req_i && is_bsr_i && mode_i == COAG_M_REL16) |=>
      (tgt_q == $past(next_pc_i) + {{8{$past(ext_i[15])}}, $past(ext_i[15:0])}))
      else $error("subroutine branch target wrong");
   // indirect request goes straight to the pointer fetch
   ptr_addr_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE12]
      (st_q == COAG_ST_IDLE && req_i && mode_i == COAG_M_IND) |=>
      (mem_req_o && mem_addr_o == {COAG_PTR_PAGE, $past(ext_i[7:0])}))
      else $error("pointer address wrong");
   ind_fetch_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE15]
      (mem_req_o) |-> (mem_long_o && mem_addr_o[15:8] == COAG_PTR_PAGE))
      else $error("pointer fetch not low-page longword");
   // one accepted read ends the fetch
   single_fetch_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE13]
      (mem_req_o && mem_ack_i) |=> !mem_req_o)
      else $error("pointer read repeated");
   ind_target_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE14]
      (mem_req_o && mem_ack_i) |=> (target_o == $past(mem_rdata_i[23:0])) ##1 done_o)
      else $error("indirect target wrong");
endmodule
`default_nettype wire

// ===== dv/coag_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// pointer memory behind the indirect fetch
module coag_mem_model (
   // clock
   input wire logic core_clk_i,
   // request side
   input wire logic mem_req_i,
   input wire logic [15:0] mem_addr_i,
   // answer side
   output logic mem_ack_o,
   output logic [31:0] mem_rdata_o
);
   int wait_n;  // stall before the answer
   // one answer per request; data toggles whenever not acknowledged
   initial begin
      mem_ack_o = 1'b0;
      mem_rdata_o = 32'h5a5a5a5a;
      forever begin
         @(negedge core_clk_i);
         if (mem_req_i === 1'b1) begin
            wait_n = $urandom % 4;
            repeat (wait_n) begin
               mem_rdata_o <= ~mem_rdata_o;
               @(negedge core_clk_i);
            end
            // top byte a5 must be dropped by the reader
            mem_ack_o <= 1'b1;
            mem_rdata_o <= {8'ha5, mem_addr_i[7:0], ~mem_addr_i[7:0], mem_addr_i[7:0] ^ 8'h3c};
            @(negedge core_clk_i);
            mem_ack_o <= 1'b0;
         end
         mem_rdata_o <= ~mem_rdata_o;  // no stale data
      end
   end
endmodule
`default_nettype wire

// ===== dv/cpu_operand_address_generation_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// self-checking bench for the address generator
module cpu_operand_address_generation_bench
   import coag_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_i = 1'b0, is_bsr_i = 1'b0;
   coag_mode_e mode_i = COAG_M_ABS8;
   coag_size_e size_i = COAG_S_BYTE;
   logic [23:0] next_pc_i = 24'h000000;
   logic [31:0] ext_i = 32'h00000000;
   logic [2:0] op_field_i = 3'h0;
   logic [1:0] small_k_i = 2'h0;
   logic mem_req_o, mem_long_o, mem_ack_i, done_o, bit_o, busy_o;
   logic [15:0] mem_addr_o, ea_o;
   logic [23:0] target_o;
   logic [31:0] mem_rdata_i, operand_o;
   logic [3:0] bcd_hi_o, bcd_lo_o;
   int fails = 0, samples_checked = 0;
   // 50 MHz clock
   always #10 core_clk_i = ~core_clk_i;
   coag_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i), .mode_i(mode_i),
      .size_i(size_i), .next_pc_i(next_pc_i), .ext_i(ext_i), .op_field_i(op_field_i),
      .small_k_i(small_k_i), .is_bsr_i(is_bsr_i), .mem_req_o(mem_req_o),
      .mem_addr_o(mem_addr_o), .mem_long_o(mem_long_o), .mem_ack_i(mem_ack_i),
      .mem_rdata_i(mem_rdata_i), .done_o(done_o), .ea_o(ea_o), .target_o(target_o),
      .operand_o(operand_o), .bcd_hi_o(bcd_hi_o), .bcd_lo_o(bcd_lo_o), .bit_o(bit_o),
      .busy_o(busy_o));
   coag_mem_model mem (.core_clk_i(core_clk_i), .mem_req_i(mem_req_o),
      .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
   // ==========================================
   // comparison and verdict
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // operand after size masking
   function automatic logic [31:0] exp_fmt(coag_size_e s, logic [31:0] x);
      if (s == COAG_S_LONG) return x;
      if (s == COAG_S_WORD) return {16'h0000, x[15:0]};
      return {24'h000000, x[7:0]};
   endfunction
   // implied constant by select code
   function automatic logic [31:0] exp_k(logic [1:0] k);
      return (k == 2'h1) ? 32'h2 : (k == 2'h2) ? 32'h4 : 32'h1;
   endfunction
   // ==========================================
   // one request, wait for done, compare
   task automatic run_op(input coag_mode_e m, input coag_size_e s, input logic [31:0] x,
                         input logic [23:0] pc, input logic [2:0] f, input logic [1:0] k);
      int n;
      logic [15:0] fa;
      logic fl, fs;
      n = 0;
      fs = 1'b0;
      fa = 16'h0000;
      fl = 1'b0;
      req_i <= 1'b1;
      mode_i <= m;
      size_i <= s;
      ext_i <= x;
      next_pc_i <= pc;
      op_field_i <= f;
      small_k_i <= k;
      is_bsr_i <= (m == COAG_M_REL8 || m == COAG_M_REL16);
      @(negedge core_clk_i);
      req_i <= 1'b0;
      while (done_o !== 1'b1 && n < 40) begin
         if (mem_req_o === 1'b1) begin
            fs = 1'b1;
            fa = mem_addr_o;
            fl = mem_long_o;
         end
         @(negedge core_clk_i);
         n++;
      end
      chk("done", {31'h0, done_o}, 32'h1);
      case (m)
         COAG_M_ABS8: chk("ea", ea_o, {COAG_SHORT_PAGE, x[7:0]});
         COAG_M_ABS16, COAG_M_ABS24: chk("ea", ea_o, x[15:0]);
         COAG_M_IMPL: chk("operand", operand_o, exp_fmt(s, exp_k(k)));
         COAG_M_BITNO: chk("bit", bit_o, x[f]);
         COAG_M_TRAP: chk("ea", ea_o,
            {COAG_ZERO8, COAG_TRAP_BASE} + {12'h000, f[1:0], 2'b00});
         // targets wrap inside the 24-bit pc
         COAG_M_REL8: chk("target", target_o, 24'(pc + {{16{x[7]}}, x[7:0]}));
         COAG_M_REL16: chk("target", target_o, 24'(pc + {{8{x[15]}}, x[15:0]}));
         COAG_M_IND: begin
            chk("fetch", fs, 1'b1);
            chk("long", fl, 1'b1);
            chk("ptr", fa, {8'h00, x[7:0]});
            chk("target", target_o, {x[7:0], ~x[7:0], x[7:0] ^ 8'h3c});
            chk("idle", busy_o, 1'b0);
         end
         default: chk("operand", operand_o, exp_fmt(s, x));
      endcase
      if (s == COAG_S_BCD) chk("bcd", {bcd_hi_o, bcd_lo_o}, x[7:0]);
      if (s == COAG_S_BIT) chk("bit", bit_o, x[f]);
      @(negedge core_clk_i);
   endtask
   // ==========================================
   // main sequence: corners, then random mix
   initial begin
      coag_mode_e m;
      coag_size_e s;
      void'($urandom(32'h069c686d));
      repeat (20) @(negedge core_clk_i);
      rst_i <= 1'b0;
      @(negedge core_clk_i);
      run_op(COAG_M_REL8, COAG_S_LONG, 32'h80, 24'h000010, 3'h0, 2'h0);
      run_op(COAG_M_REL8, COAG_S_LONG, 32'h7f, 24'hffffff, 3'h0, 2'h0);
      run_op(COAG_M_REL16, COAG_S_LONG, 32'h8000, 24'h000002, 3'h0, 2'h0);
      run_op(COAG_M_ABS8, COAG_S_BYTE, 32'hffffffff, 24'h0, 3'h0, 2'h0);
      run_op(COAG_M_IND, COAG_S_LONG, 32'hffffffff, 24'h0, 3'h0, 2'h0);
      run_op(COAG_M_BITNO, COAG_S_BIT, 32'h80, 24'h0, 3'h7, 2'h0);
      for (int i = 0; i < 300; i++) begin
         m = coag_mode_e'(i % 12);
         case (m)
            // byte immediates alternate between plain byte and bcd view
            COAG_M_IMM8: s = coag_size_e'(1 + (i / 12) % 2);
            COAG_M_IMM16: s = COAG_S_WORD;
            COAG_M_BITNO: s = COAG_S_BIT;
            default: s = COAG_S_LONG;
         endcase
         run_op(m, s, $urandom, $urandom, $urandom, $urandom);
      end
      test_done();
   end
   // watchdog against a hung handshake
   initial begin
      #400000;
      fails++;
      test_done();
   end
endmodule
`default_nettype wire
